// File: wsps_pkg.sv
// Package of constants and types for the wheel sensor pulse simulator
package wsps_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int          CLK_HZ        = 200_000_000;
  localparam int          CLK_MHZ       = 200;
  localparam int          LIMIT_HZ      = 20_000;      // Highest tooth frequency
  localparam int          MIN_PULSE_NS  = 5_000;       // Least high or low time
  localparam logic [15:0] MIN_PULSE_CYC = 16'((MIN_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam int          STOP_TIME_MS  = 150;         // Standstill repeat time
  localparam int          STOP_CYC      = STOP_TIME_MS * (CLK_HZ / 1000);
  localparam logic [15:0] CIRC_MUL      = 16'hC91;     // 2*pi scaled by 2^9
  localparam int          CIRC_SHIFT    = 9;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_FREQ   = 8'h04;
  localparam logic [7:0] ADDR_SPEED  = 8'h08;
  localparam logic [7:0] ADDR_RADIUS = 8'h0C;
  localparam logic [7:0] ADDR_RATIO  = 8'h10;
  localparam logic [7:0] ADDR_TEETH  = 8'h14;
  localparam logic [7:0] ADDR_BITLEN = 8'h18;
  localparam logic [7:0] ADDR_CHAN   = 8'h1C;
  localparam logic [7:0] ADDR_PROTO  = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_DROP0  = 8'h28;      // Four drop entries, 4 bytes apart

  // ==========================================================================
  // Field positions
  localparam int DROP_FIRST_LSB = 0;               // First tooth of a range
  localparam int DROP_LAST_LSB  = 8;               // Last tooth of a range
  localparam int DROP_VALID_BIT = 16;
  localparam int ST_OVER_BIT    = 0;               // Live over-limit
  localparam int ST_STICKY_BIT  = 1;               // Sticky over-limit, write 1 clears
  localparam int ST_POLE_BIT    = 2;
  localparam int ST_TOOTH_LSB   = 8;

  // ==========================================================================
  // Reset values and limits
  localparam logic [7:0]  TEETH_RST   = 8'h30;     // 48 teeth
  localparam logic [7:0]  TEETH_MAX   = 8'h80;
  localparam logic [7:0]  BITLEN_RST  = 8'h32;     // 50 us
  localparam logic [9:0]  RATIO_RST   = 10'h200;   // One half, in 1/1024
  localparam logic [9:0]  RATIO_MIN   = 10'h034;   // 0.05
  localparam logic [9:0]  RATIO_MAX   = 10'h3CC;   // 0.95
  localparam logic [15:0] RADIUS_RST  = 16'h0140;  // 320 mm
  localparam logic [2:0]  CHAN_MAX    = 3'h5;
  localparam int          NUM_CHAN    = 6;
  localparam int          NUM_DROP    = 4;

  // ==========================================================================
  // Output levels
  localparam logic [1:0] LVL_OFF   = 2'h0;
  localparam logic [1:0] LVL_LOW   = 2'h1;
  localparam logic [1:0] LVL_HIGH  = 2'h2;
  localparam logic [1:0] LVL_FAULT = 2'h3;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    WSPS_IDLE = 3'b001,
    WSPS_HIGH = 3'b010,
    WSPS_LOW  = 3'b100
  } wsps_state_t;

  typedef struct packed {
    logic parity_odd;      // Bit 7
    logic defect_pattern_on;
    logic stop_pulse_control;
    logic placement_fault_inject;
    logic gap_fault_inject;
    logic limit_mode;      // 0 ratio window, 1 least pulse time
    logic freq_mode;       // 0 speed, 1 direct frequency
    logic enable;          // Bit 0
  } wsps_ctrl_t;

  typedef struct packed {
    logic [NUM_CHAN-1:0][1:0] ch_level;
    logic                     gap_err;
    logic                     place_err;
    logic                     stop_pulse;
    logic [8:0]               proto;
  } wsps_out_t;

endpackage : wsps_pkg

// File: wsps_core.sv
// Wheel speed sensor pulse simulator with register port
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

module wsps_core #(
  parameter int STOP_CYCLES = wsps_pkg::STOP_CYC
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Sensor output group
  output wsps_pkg::wsps_out_t    sensor_out
);

  // ==========================================================================
  // Functions
  function automatic logic [31:0] abs32(input logic signed [31:0] v);
    abs32 = v[31] ? 32'(-v) : 32'(v);
  endfunction : abs32

  function automatic logic in_list(input logic [7:0] tooth,
                                   input logic [wsps_pkg::NUM_DROP-1:0][16:0] list);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < wsps_pkg::NUM_DROP; i++) begin
      if (list[i][wsps_pkg::DROP_VALID_BIT] &&
          tooth >= list[i][wsps_pkg::DROP_FIRST_LSB +: 8] &&
          tooth <= list[i][wsps_pkg::DROP_LAST_LSB +: 8]) begin
        hit = 1'b1;
      end
    end
    in_list = hit;
  endfunction : in_list

  // ==========================================================================
  // Registers written by software
  wsps_pkg::wsps_ctrl_t                     ctrl;
  logic signed [31:0]                       freq_hz;
  logic signed [31:0]                       speed_mms;
  logic        [15:0]                       rolling_radius;
  logic        [9:0]                        pole_ratio;
  logic        [7:0]                        teeth;
  logic        [7:0]                        bitlen_us;
  logic        [2:0]                        chan;
  logic        [7:0]                        proto_free;
  logic        [wsps_pkg::NUM_DROP-1:0][16:0] drop_list;
  logic                                     over_sticky;

  // Block state
  wsps_pkg::wsps_state_t state;
  wsps_pkg::wsps_state_t next_state;
  logic [47:0]           acc;
  logic [15:0]           pole_cnt;
  logic                  pend;
  logic [7:0]            tooth_num;
  logic [31:0]           stop_timer;
  logic [15:0]           stop_left;
  logic                  over_live;

  // ==========================================================================
  // Address decode
  wire wr_ctrl   = reg_wr && reg_addr == wsps_pkg::ADDR_CTRL;
  wire wr_freq   = reg_wr && reg_addr == wsps_pkg::ADDR_FREQ;
  wire wr_speed  = reg_wr && reg_addr == wsps_pkg::ADDR_SPEED;
  wire wr_radius = reg_wr && reg_addr == wsps_pkg::ADDR_RADIUS;
  wire wr_ratio  = reg_wr && reg_addr == wsps_pkg::ADDR_RATIO;
  wire wr_teeth  = reg_wr && reg_addr == wsps_pkg::ADDR_TEETH;
  wire wr_bitlen = reg_wr && reg_addr == wsps_pkg::ADDR_BITLEN;
  wire wr_chan   = reg_wr && reg_addr == wsps_pkg::ADDR_CHAN;
  wire wr_proto  = reg_wr && reg_addr == wsps_pkg::ADDR_PROTO;
  wire wr_status = reg_wr && reg_addr == wsps_pkg::ADDR_STATUS;
  wire [7:0] drop_off = reg_addr - wsps_pkg::ADDR_DROP0;
  wire wr_drop   = reg_wr && reg_addr >= wsps_pkg::ADDR_DROP0 &&
                   drop_off[7:4] == 4'h0 && drop_off[1:0] == 2'h0;
  wire [1:0] drop_idx = drop_off[3:2];

  // Accepted values: teeth 1..128, channel 0..5 and only while disabled
  wire teeth_ok = reg_wdata[7:0] != 8'h00 && reg_wdata[7:0] <= wsps_pkg::TEETH_MAX;
  wire chan_ok  = !ctrl.enable && reg_wdata[2:0] <= wsps_pkg::CHAN_MAX;

  // ==========================================================================
  // Rate source and clamp
  wire [31:0] abs_freq   = abs32(freq_hz);
  wire [31:0] abs_speed  = abs32(speed_mms);
  wire [31:0] circ_prod  = 32'(rolling_radius) * 32'(wsps_pkg::CIRC_MUL);
  wire [15:0] circ_mm    = circ_prod[wsps_pkg::CIRC_SHIFT +: 16];
  wire [47:0] inc_speed  = 48'(abs_speed) * 48'(teeth);
  wire [47:0] inc_raw    = ctrl.freq_mode ? 48'(abs_freq) : inc_speed;
  wire [47:0] lim        = ctrl.freq_mode ? 48'(wsps_pkg::LIMIT_HZ)
                                          : 48'(circ_mm) * 48'(wsps_pkg::LIMIT_HZ);
  wire [47:0] modulus    = ctrl.freq_mode ? 48'(wsps_pkg::CLK_HZ)
                                          : 48'(circ_mm) * 48'(wsps_pkg::CLK_HZ);
  wire        over       = inc_raw > lim;
  wire [47:0] inc        = over ? lim : inc_raw;
  wire        run        = ctrl.enable && modulus != 48'h0 && inc != 48'h0;
  wire        negative   = ctrl.freq_mode ? freq_hz[31] : speed_mms[31];

  // Phase accumulator wraps once per tooth period
  wire [47:0] sum        = acc + inc;
  wire        wrap       = run && sum >= modulus;
  wire [47:0] next_acc   = wrap ? sum - modulus : sum;

  // ==========================================================================
  // Pole split
  wire [9:0]  ratio_win  = pole_ratio < wsps_pkg::RATIO_MIN ? wsps_pkg::RATIO_MIN :
                           pole_ratio > wsps_pkg::RATIO_MAX ? wsps_pkg::RATIO_MAX :
                           pole_ratio;
  wire [9:0]  ratio_eff  = ctrl.limit_mode ? pole_ratio : ratio_win;
  wire [47:0] hi_thr     = 48'(modulus[47:10]) * 48'(ratio_eff);
  wire        min_ok     = !ctrl.limit_mode ||
                           pole_cnt >= wsps_pkg::MIN_PULSE_CYC;
  wire        high_end   = acc >= hi_thr && min_ok;
  wire        tooth_go   = (pend || wrap) && min_ok;

  // Pulse state machine
  always_comb begin
    case (state)
      wsps_pkg::WSPS_IDLE: next_state = wsps_pkg::WSPS_LOW;
      wsps_pkg::WSPS_HIGH: next_state = high_end ? wsps_pkg::WSPS_LOW : wsps_pkg::WSPS_HIGH;
      wsps_pkg::WSPS_LOW:  next_state = tooth_go ? wsps_pkg::WSPS_HIGH : wsps_pkg::WSPS_LOW;
      default:             next_state = wsps_pkg::WSPS_IDLE;
    endcase
  end

  wire tooth_start = state == wsps_pkg::WSPS_LOW && tooth_go;
  wire [7:0] next_tooth = tooth_num >= teeth ? 8'h01 : tooth_num + 8'h01;
  wire pole_change = next_state != state;

  // ==========================================================================
  // Standstill timing
  wire [15:0] bit_cycles = 16'(bitlen_us) * 16'(wsps_pkg::CLK_MHZ);
  wire        expire     = stop_timer >= 32'(STOP_CYCLES - 1);
  wire        stop_start = ctrl.enable && ctrl.stop_pulse_control && expire;
  wire        stop_rst   = tooth_start || expire;

  // ==========================================================================
  // Output composition
  wire        defect     = ctrl.defect_pattern_on && in_list(tooth_num, drop_list);
  wire [1:0]  pole_lvl   = state == wsps_pkg::WSPS_HIGH ? wsps_pkg::LVL_HIGH : wsps_pkg::LVL_LOW;
  wire [1:0]  level      = !ctrl.enable              ? wsps_pkg::LVL_OFF :
                           stop_left != 16'h0        ? wsps_pkg::LVL_HIGH :
                           defect                    ? wsps_pkg::LVL_FAULT :
                           pole_lvl;
  wire [7:0]  proto_low  = {proto_free[7:5], negative, proto_free[3:1],
                            ctrl.gap_fault_inject};
  wire [8:0]  proto_word = {^proto_low ^ ctrl.parity_odd, proto_low};

  wsps_pkg::wsps_out_t next_out;
  always_comb begin
    next_out            = '0;
    next_out.ch_level[chan] = level;
    next_out.gap_err    = ctrl.enable && ctrl.gap_fault_inject;
    next_out.place_err  = ctrl.enable && ctrl.placement_fault_inject;
    next_out.stop_pulse = ctrl.enable && stop_left != 16'h0;
    next_out.proto      = proto_word;
  end

  // ==========================================================================
  // Read selection
  wire [wsps_pkg::NUM_DROP-1:0][16:0] dl = drop_list;
  wire [31:0] status_word = {16'h0, tooth_num, 5'h0,
                             state == wsps_pkg::WSPS_HIGH, over_sticky, over_live};
  wire [31:0] next_rdata =
    !reg_rd                                 ? 32'h0 :
    reg_addr == wsps_pkg::ADDR_CTRL         ? {24'h0, ctrl} :
    reg_addr == wsps_pkg::ADDR_FREQ         ? freq_hz :
    reg_addr == wsps_pkg::ADDR_SPEED        ? speed_mms :
    reg_addr == wsps_pkg::ADDR_RADIUS       ? {16'h0, rolling_radius} :
    reg_addr == wsps_pkg::ADDR_RATIO        ? {22'h0, pole_ratio} :
    reg_addr == wsps_pkg::ADDR_TEETH        ? {24'h0, teeth} :
    reg_addr == wsps_pkg::ADDR_BITLEN       ? {24'h0, bitlen_us} :
    reg_addr == wsps_pkg::ADDR_CHAN         ? {29'h0, chan} :
    reg_addr == wsps_pkg::ADDR_PROTO        ? {24'h0, proto_free} :
    reg_addr == wsps_pkg::ADDR_STATUS       ? status_word :
    (reg_addr >= wsps_pkg::ADDR_DROP0 && drop_off[7:4] == 4'h0 && drop_off[1:0] == 2'h0)
                                            ? {15'h0, dl[drop_idx]} :
    32'h0;

  // ==========================================================================
  // Software-written registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl           <= '0;
      freq_hz        <= '0;
      speed_mms      <= '0;
      rolling_radius <= wsps_pkg::RADIUS_RST;
      pole_ratio     <= wsps_pkg::RATIO_RST;
      teeth          <= wsps_pkg::TEETH_RST;
      bitlen_us      <= wsps_pkg::BITLEN_RST;
      chan           <= 3'h0;
      proto_free     <= 8'h00;
      drop_list      <= '0;
    end else begin
      if (wr_ctrl)   ctrl           <= wsps_pkg::wsps_ctrl_t'(reg_wdata[7:0]);
      if (wr_freq)   freq_hz        <= reg_wdata;
      if (wr_speed)  speed_mms      <= reg_wdata;
      if (wr_radius) rolling_radius <= reg_wdata[15:0];
      if (wr_ratio)  pole_ratio     <= reg_wdata[9:0];
      if (wr_teeth && teeth_ok) teeth <= reg_wdata[7:0];
      if (wr_bitlen) bitlen_us      <= reg_wdata[7:0];
      if (wr_chan && chan_ok) chan  <= reg_wdata[2:0];
      if (wr_proto)  proto_free     <= reg_wdata[7:0];
      if (wr_drop)   drop_list[drop_idx] <= reg_wdata[16:0];
    end
  end

  // Over-limit flags; a new excess wins over a clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      over_live   <= 1'b0;
      over_sticky <= 1'b0;
    end else begin
      over_live   <= run && over;
      over_sticky <= (run && over) ||
                     (over_sticky && !(wr_status && reg_wdata[wsps_pkg::ST_STICKY_BIT]));
    end
  end

  // Tooth generator
  always_ff @(posedge mclk) begin
    if (rst || !ctrl.enable) begin
      state     <= wsps_pkg::WSPS_IDLE;
      acc       <= 48'h0;
      pole_cnt  <= 16'h0;
      pend      <= 1'b0;
      tooth_num <= 8'h00;
    end else begin
      state     <= next_state;
      acc       <= next_acc;
      pole_cnt  <= pole_change ? 16'h0 :
                   pole_cnt == 16'hFFFF ? pole_cnt : pole_cnt + 16'h1;
      pend      <= (pend || wrap) && !tooth_start;
      if (tooth_start) tooth_num <= next_tooth;
    end
  end

  // Standstill timer and pulse
  always_ff @(posedge mclk) begin
    if (rst || !ctrl.enable) begin
      stop_timer <= 32'h0;
      stop_left  <= 16'h0;
    end else begin
      stop_timer <= stop_rst ? 32'h0 : stop_timer + 32'h1;
      // A pulse in flight is cut as soon as the standstill control goes off
      stop_left  <= stop_start ? bit_cycles :
                    !ctrl.stop_pulse_control ? 16'h0 :
                    stop_left != 16'h0 ? stop_left - 16'h1 : 16'h0;
    end
  end

  // Registered outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      sensor_out <= '0;
      reg_rdata  <= 32'h0;
    end else begin
      sensor_out <= next_out;
      reg_rdata  <= next_rdata;
    end
  end

endmodule : wsps_core

// File: wsps_chk.sv
// Checker of the wheel sensor pulse simulator port behaviour
`timescale 1ns/1ps

module wsps_chk #(
  parameter int STOP_CYCLES = wsps_pkg::STOP_CYC
) (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                rst,
  // Register port
  input wire logic [7:0]          reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  // Sensor output group
  input wire wsps_pkg::wsps_out_t sensor_out
);
  // ==========================================================================
  // Shadow of the control values as software wrote them
  wsps_pkg::wsps_ctrl_t sh;
  logic [2:0]           sh_chan;
  logic                 f_neg;
  logic                 s_neg;
  logic                 neg;

  // Sign follows the active rate source
  assign neg = sh.freq_mode ? f_neg : s_neg;

  // Channel writes are dropped while enabled or out of range
  always_ff @(posedge mclk) begin
    if (rst) begin
      sh      <= '0;
      sh_chan <= 3'h0;
      f_neg   <= 1'b0;
      s_neg   <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == wsps_pkg::ADDR_CTRL) sh <= wsps_pkg::wsps_ctrl_t'(reg_wdata[7:0]);
      if (reg_addr == wsps_pkg::ADDR_FREQ) f_neg <= reg_wdata[31];
      if (reg_addr == wsps_pkg::ADDR_SPEED) s_neg <= reg_wdata[31];
      if (reg_addr == wsps_pkg::ADDR_CHAN && !sh.enable && reg_wdata[2:0] <= wsps_pkg::CHAN_MAX)
        sh_chan <= reg_wdata[2:0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Port relations
  chk_off_quiet: assert property (!$past(sh.enable) && !$past(sh.enable, 2) |->
    sensor_out.ch_level == '0 && !sensor_out.stop_pulse) else $error("levels while disabled");
  chk_one_chan: assert property ((sensor_out.ch_level & ~(12'h3 << (2 * $past(sh_chan))))
    == 12'h0) else $error("level on unselected channel");
  chk_gap_flag: assert property (sensor_out.gap_err ==
    $past(sh.enable & sh.gap_fault_inject)) else $error("gap flag wrong");
  chk_place_flag: assert property (sensor_out.place_err ==
    $past(sh.enable & sh.placement_fault_inject)) else $error("placement flag wrong");
  chk_proto_gap: assert property (sensor_out.proto[0] ==
    $past(sh.gap_fault_inject)) else $error("protocol gap bit wrong");
  chk_proto_sign: assert property (sensor_out.proto[4] == $past(neg))
    else $error("protocol sign bit wrong");
  chk_proto_parity: assert property ((^sensor_out.proto) == $past(sh.parity_odd))
    else $error("protocol parity wrong");
  chk_stop_gate: assert property (sensor_out.stop_pulse |->
    $past(sh.stop_pulse_control) || $past(sh.stop_pulse_control, 2))
    else $error("standstill pulse while off");
  chk_fault_gate: assert property (
    sensor_out.ch_level[$past(sh_chan)] == wsps_pkg::LVL_FAULT |->
    $past(sh.defect_pattern_on) || $past(sh.defect_pattern_on, 2))
    else $error("fault level while pattern off");
endmodule : wsps_chk

bind wsps_core wsps_chk #(.STOP_CYCLES(STOP_CYCLES)) wsps_chk_i (.mclk(mclk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sensor_out(sensor_out));

// File: wsps_vcu.sv
// Control unit model that times the tooth pulses of one channel
`timescale 1ns/1ps

module wsps_vcu (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // Sensor side
  input  wire wsps_pkg::wsps_out_t sensor_out,
  input  wire logic [2:0]          chan,
  // Measurements
  output logic [15:0]              tooth_cnt,
  output logic [15:0]              fault_cnt,
  output logic [31:0]              hi_len,
  output logic [31:0]              per_len
);
  // ==========================================================================
  // Edge detection on the watched channel
  logic [1:0]  lvl;
  logic [1:0]  lvl_q;
  logic        act;
  logic        start;
  logic [31:0] run;
  logic [31:0] hi_run;

  // A tooth starts on any step into a high or fault level
  assign lvl   = sensor_out.ch_level[chan];
  assign act   = (lvl == wsps_pkg::LVL_HIGH) || (lvl == wsps_pkg::LVL_FAULT);
  assign start = act && (lvl != lvl_q);

  // Period from start to start, pulse from start to drop
  always_ff @(posedge mclk) begin
    if (rst) begin
      {lvl_q, tooth_cnt, fault_cnt} <= '0;
      {hi_len, per_len, run, hi_run} <= '0;
    end else begin
      lvl_q  <= lvl;
      run    <= start ? 32'h1 : run + 32'h1;
      hi_run <= start ? 32'h1 : hi_run + 32'h1;
      if (start) tooth_cnt <= tooth_cnt + 16'h1;
      if (start) per_len <= run;
      if (start && lvl == wsps_pkg::LVL_FAULT) fault_cnt <= fault_cnt + 16'h1;
      if (!act && lvl_q inside {wsps_pkg::LVL_HIGH, wsps_pkg::LVL_FAULT}) hi_len <= hi_run;
    end
  end
endmodule : wsps_vcu

// File: wsps_core_test.sv
// Testbench of the wheel sensor pulse simulator
`timescale 1ns/1ps

module wsps_core_test;
  // ==========================================================================
  // Signals
  logic                mclk;
  logic                rst;
  logic [7:0]          reg_addr;
  logic [31:0]         reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [31:0]         reg_rdata;
  wsps_pkg::wsps_out_t sensor_out;
  logic [15:0]         tooth_cnt;
  logic [15:0]         fault_cnt;
  logic [31:0]         hi_len;
  logic [31:0]         per_len;
  logic [31:0]         v;
  logic [15:0]         f0;
  int                  err_total = 0;
  int                  checked = 0;

  // Design and control unit model
  wsps_core #(.STOP_CYCLES(2000)) wsps_core_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sensor_out(sensor_out));
  wsps_vcu wsps_vcu_i (.mclk(mclk), .rst(rst), .sensor_out(sensor_out), .chan(3'h3),
    .tooth_cnt(tooth_cnt), .fault_cnt(fault_cnt), .hi_len(hi_len), .per_len(per_len));

  // Clock of 5 ns
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ==========================================================================
  // Tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask : rd_chk

  // Pulse times may differ by a cycle or two of phase rounding
  function automatic logic [31:0] near(input logic [31:0] s, input logic [31:0] e);
    return (s + 32'h2 >= e && s <= e + 32'h2) ? e : s;
  endfunction : near

  task automatic wait_teeth(input int n);
    int t0;
    int k;
    t0 = tooth_cnt;
    k  = 0;
    while (int'(tooth_cnt) - t0 < n && k < 60000) begin
      @(posedge mclk);
      k++;
    end
    check("tooth count", 32'(int'(tooth_cnt) - t0), 32'(n));
  endtask : wait_teeth

  task automatic give_verdict();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // Watchdog against a hang
  initial begin
    #750_000;
    err_total++;
    give_verdict();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    {rst, reg_wr, reg_rd} = 3'b100;
    {reg_addr, reg_wdata} = '0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_chk("teeth", wsps_pkg::ADDR_TEETH, 32'h30);
    rd_chk("bitlen", wsps_pkg::ADDR_BITLEN, 32'h32);
    rd_chk("ratio", wsps_pkg::ADDR_RATIO, 32'h200);
    rd_chk("drop0", wsps_pkg::ADDR_DROP0, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    wr(wsps_pkg::ADDR_TEETH, 32'h0);
    wr(wsps_pkg::ADDR_TEETH, 32'h81);
    rd_chk("teeth refused", wsps_pkg::ADDR_TEETH, 32'h30);
    wr(wsps_pkg::ADDR_TEETH, 32'h80);
    rd_chk("teeth top", wsps_pkg::ADDR_TEETH, 32'h80);
    wr(wsps_pkg::ADDR_CHAN, 32'h3);
    wr(wsps_pkg::ADDR_CHAN, 32'h6);
    rd_chk("chan", wsps_pkg::ADDR_CHAN, 32'h3);
    $display("TEST reset done");
    // Standstill pulses with odd parity, then with standstill off
    wr(wsps_pkg::ADDR_BITLEN, 32'h2);
    wr(wsps_pkg::ADDR_CTRL, 32'hA3);
    wait_teeth(3);
    check("stop period", per_len, 32'd2000);
    check("stop width", hi_len, 32'd400);
    check("stop flag", 32'(sensor_out.stop_pulse), 32'h1);
    wr(wsps_pkg::ADDR_CTRL, 32'h03);
    f0 = tooth_cnt;
    repeat (5000) @(posedge mclk);
    check("stop off", 32'(tooth_cnt - f0), 32'h0);
    $display("TEST standstill done");
    // Direct frequency above the limit, negative
    wr(wsps_pkg::ADDR_CTRL, 32'h0);
    wr(wsps_pkg::ADDR_FREQ, -32'sd30000);
    wr(wsps_pkg::ADDR_CTRL, 32'h3);
    wait_teeth(2);
    check("period", per_len, 32'd10000);
    check("high", near(hi_len, 32'd5000), 32'd5000);
    check("low", near(per_len - hi_len, 32'd5000), 32'd5000);
    check("sign", 32'(sensor_out.proto[4]), 32'h1);
    rd(wsps_pkg::ADDR_STATUS, v);
    check("over", v & 32'h3, 32'h3);
    wr(wsps_pkg::ADDR_CHAN, 32'h1);
    rd_chk("chan locked", wsps_pkg::ADDR_CHAN, 32'h3);
    wr(wsps_pkg::ADDR_FREQ, 32'd20000);
    wr(wsps_pkg::ADDR_STATUS, 32'h2);
    rd(wsps_pkg::ADDR_STATUS, v);
    check("over cleared", v & 32'h3, 32'h0);
    // Ratio below the window
    wr(wsps_pkg::ADDR_RATIO, 32'd10);
    wait_teeth(2);
    check("ratio floor", near(hi_len, 32'd508), 32'd508);
    $display("TEST frequency done");
    // Least pole time and defective second tooth
    wr(wsps_pkg::ADDR_CTRL, 32'h0);
    wr(wsps_pkg::ADDR_TEETH, 32'h2);
    wr(wsps_pkg::ADDR_DROP0, 32'h10202);
    wr(wsps_pkg::ADDR_CTRL, 32'h47);
    f0 = fault_cnt;
    wait_teeth(4);
    check("faults", 32'(fault_cnt - f0), 32'h2);
    check("least pole", near(hi_len, 32'd1000), 32'd1000);
    rd(wsps_pkg::ADDR_STATUS, v);
    check("tooth number", v & 32'hFF04, 32'h0204);
    $display("TEST defect done");
    // Speed mode at exactly the limit, frequency register ignored
    wr(wsps_pkg::ADDR_CTRL, 32'h0);
    wr(wsps_pkg::ADDR_TEETH, 32'h30);
    wr(wsps_pkg::ADDR_SPEED, 32'd837500);
    wr(wsps_pkg::ADDR_FREQ, -32'sd5);
    wr(wsps_pkg::ADDR_RATIO, 32'h200);
    wr(wsps_pkg::ADDR_PROTO, 32'hFF);
    wr(wsps_pkg::ADDR_CTRL, 32'h19);
    wait_teeth(2);
    check("speed period", near(per_len, 32'd10000), 32'd10000);
    check("speed sign", 32'(sensor_out.proto[4]), 32'h0);
    check("proto word", 32'(sensor_out.proto), 32'h1EF);
    check("gap flag", 32'(sensor_out.gap_err), 32'h1);
    check("place flag", 32'(sensor_out.place_err), 32'h1);
    rd(wsps_pkg::ADDR_STATUS, v);
    check("no over", v & 32'h1, 32'h0);
    $display("TEST speed done");
    give_verdict();
  end
endmodule : wsps_core_test
